// file: verif/watchdog_with_reset_flags_tb.sv
// Self-checking bench for the watchdog with reset-cause flags.
// Assumes short divide and base counts so time-outs take few cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))

module watchdog_with_reset_flags_tb;
   localparam int          DIV = 4;
   localparam int          BASE = 4;
   localparam logic [11:0] S = wdt_pkg::ADDR_STATUS;
   localparam logic [11:0] C = wdt_pkg::ADDR_CONTROL;
   logic        pclk = 1'b0, presetn = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, timeout_irq, watchdog_reset_pulse;
   logic        safety_level_fuse = 1'b0, watchdog_clear_instruction = 1'b0;
   logic        brownout_reset_event = 1'b0, external_reset_event = 1'b0;
   logic        global_irq_enable = 1'b0, irq_vector_taken = 1'b0;
   int          miscompares = 0, checks_done = 0, cycles = 0, pulses = 0;
   int          n, lo;

   wdt_top #(.OSC_DIV(DIV), .BASE_TICKS(BASE)) DUT (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .safety_level_fuse, .watchdog_clear_instruction, .brownout_reset_event,
      .external_reset_event, .global_irq_enable, .irq_vector_taken,
      .timeout_irq, .watchdog_reset_pulse);

   always #2 pclk = ~pclk;

   always @(posedge pclk)
   begin
      cycles++;
      if (watchdog_reset_pulse === 1'b1)
         pulses++;
      if (cycles == 5000)
      begin
         miscompares++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   // A back-to-back call keeps psel up; otherwise one idle cycle follows.
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic bb);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      penable <= 1'b0;
      if (!bb)
      begin
         psel <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb

   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h00000000, 1'b0);
      `CHK(rd, e);
   endtask : rchk

   task automatic clr();
      watchdog_clear_instruction <= 1'b1;
      @(posedge pclk);
      watchdog_clear_instruction <= 1'b0;
   endtask : clr

   task automatic wait_hi(input int lim);
      n = 0;
      while (watchdog_reset_pulse !== 1'b1 && n < lim)
      begin
         @(posedge pclk);
         n++;
      end
   endtask : wait_hi

   task automatic done(input string s);
      $display("Test %s finished at %0t", s, $time);
   endtask : done

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rchk(S, 32'h01);
      rchk(C, 32'h00);
      apb(1'b0, 12'h008, 32'h00000000, 1'b0);
      `CHK(err, 1'b1);
      `CHK(rd, 32'h0);
      done("reset values");
      apb(1'b1, S, 32'h0, 1'b0);
      rchk(S, 32'h00);
      brownout_reset_event <= 1'b1;
      @(posedge pclk);
      brownout_reset_event <= 1'b0;
      external_reset_event <= 1'b1;
      @(posedge pclk);
      external_reset_event <= 1'b0;
      rchk(S, 32'h06);
      apb(1'b1, S, 32'hFFFFFF04, 1'b0);
      rchk(S, 32'h04);
      apb(1'b1, S, 32'h0, 1'b0);
      rchk(S, 32'h00);
      done("reset flags");
      apb(1'b1, C, 32'h18, 1'b1);
      apb(1'b1, C, 32'h0A, 1'b0);
      rchk(C, 32'h0A);
      apb(1'b1, C, 32'h01, 1'b0);
      rchk(C, 32'h0A);
      apb(1'b1, C, 32'h1A, 1'b1);
      apb(1'b1, C, 32'h02, 1'b0);
      rchk(C, 32'h02);
      apb(1'b1, C, 32'h08, 1'b0);
      rchk(C, 32'h0A);
      apb(1'b1, C, 32'h1A, 1'b0);
      repeat (5) @(posedge pclk);
      apb(1'b1, C, 32'h00, 1'b0);
      rchk(C, 32'h0A);
      done("change window");
      lo = pulses;
      repeat (20)
      begin
         clr();
         repeat (7) @(posedge pclk);
      end
      `CHK(pulses, lo);
      wait_hi(100);
      `CHK(watchdog_reset_pulse, 1'b1);
      repeat (3) @(posedge pclk);
      rchk(S, 32'h08);
      apb(1'b1, C, 32'h18, 1'b1);
      apb(1'b1, C, 32'h00, 1'b0);
      wait_hi(100);
      `CHK(watchdog_reset_pulse, 1'b1);
      done("reset mode");
      for (int sel = 0; sel < 3; sel++)
      begin
         apb(1'b1, S, 32'h0, 1'b0);
         apb(1'b1, C, 32'h18, 1'b1);
         apb(1'b1, C, 32'h08 | sel, 1'b0);
         clr();
         wait_hi(400);
         lo = ((BASE << sel) - 2) * DIV;
         `CHK(n >= lo && n <= (BASE << sel) * DIV + 3, 1'b1);
      end
      done("period select");
      apb(1'b1, S, 32'h0, 1'b0);
      lo = pulses;
      apb(1'b1, C, 32'h40, 1'b0);
      repeat (40) @(posedge pclk);
      `CHK(timeout_irq, 1'b0);
      `CHK(pulses, lo);
      rchk(C, 32'hC0);
      global_irq_enable <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK(timeout_irq, 1'b1);
      clr();
      irq_vector_taken <= 1'b1;
      @(posedge pclk);
      irq_vector_taken <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK(timeout_irq, 1'b0);
      // Let the flag set again so the written one has something to clear.
      repeat (20) @(posedge pclk);
      apb(1'b1, C, 32'h80, 1'b0);
      rchk(C, 32'h00);
      apb(1'b1, C, 32'h48, 1'b0);
      do
         apb(1'b0, C, 32'h0, 1'b0);
      while (rd[7] !== 1'b1);
      `CHK(rd, 32'h88);
      wait_hi(100);
      `CHK(watchdog_reset_pulse, 1'b1);
      global_irq_enable <= 1'b0;
      done("interrupt mode");
      presetn <= 1'b0;
      safety_level_fuse <= 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, C, 32'h18, 1'b1);
      apb(1'b1, C, 32'h01, 1'b0);
      rchk(C, 32'h09);
      apb(1'b1, C, 32'h02, 1'b0);
      rchk(C, 32'h09);
      wait_hi(200);
      `CHK(watchdog_reset_pulse, 1'b1);
      apb(1'b1, C, 32'h18, 1'b1);
      apb(1'b1, C, 32'h20, 1'b0);
      rchk(C, 32'h28);
      done("safety level two");
      print_verdict();
   end
endmodule : watchdog_with_reset_flags_tb

`default_nettype wire

// file: verif/wdt_monitor.sv
// Port assertions for the watchdog block.
// Assumes it is bound to wdt_top and shares its single clock.
`timescale 1ns/1ps
`default_nettype none

module wdt_monitor (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        safety_level_fuse,
   input wire logic        watchdog_clear_instruction,
   input wire logic        global_irq_enable,
   input wire logic        irq_vector_taken,
   input wire logic        timeout_irq,
   input wire logic        watchdog_reset_pulse
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   logic [3:0] open_age_r;
   wire        rd_st = pready && !pwrite && paddr == wdt_pkg::ADDR_STATUS;
   wire        rd_ct = pready && !pwrite && paddr == wdt_pkg::ADDR_CONTROL;
   wire        wr_op = pready && pwrite && paddr == wdt_pkg::ADDR_CONTROL
                       && pwdata[4] && pwdata[3];
   // Age saturates, so a read long after an opener must see the window shut.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         open_age_r <= 4'hF;
      else if (wr_op)
         open_age_r <= 4'h0;
      else if (open_age_r != 4'hF)
         open_age_r <= open_age_r + 4'h1;
   a_setup_answered:
      assert property (psel && !penable |=> pready)
      else $error("Setup not answered.");
   a_error_unmapped:
      assert property (pready && pslverr |-> paddr != wdt_pkg::ADDR_STATUS
                       && paddr != wdt_pkg::ADDR_CONTROL)
      else $error("Error on mapped address.");
   a_status_top_zero:
      assert property (rd_st |-> prdata[31:4] == 28'h0000000)
      else $error("Status upper bits not zero.");
   a_window_closes:
      assert property (rd_ct && open_age_r >= 4'h8 |-> !prdata[4])
      else $error("Change window still open.");
   a_level_two_on:
      assert property (rd_ct && safety_level_fuse
                       && $past(safety_level_fuse, 3) |-> prdata[3])
      else $error("Enable reads zero in level two.");
   a_irq_needs_global:
      assert property (timeout_irq |-> $past(global_irq_enable))
      else $error("Interrupt without global enable.");
   a_vector_clears:
      assert property (irq_vector_taken |-> ##2 !timeout_irq)
      else $error("Vector did not clear interrupt.");
   a_pulse_single:
      assert property (watchdog_reset_pulse |=> !watchdog_reset_pulse)
      else $error("Reset pulse longer than one cycle.");
   a_clear_defers:
      assert property (watchdog_reset_pulse |-> !$past(
                       watchdog_clear_instruction) && !$past(
                       watchdog_clear_instruction, 2))
      else $error("Reset pulse right after clear.");
   c_reset_pulse: cover property (watchdog_reset_pulse);
   c_irq:         cover property (timeout_irq);
   c_refused:     cover property (pready && pslverr);
endmodule : wdt_monitor

bind wdt_top wdt_monitor u_mon (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .pready, .pslverr, .safety_level_fuse,
   .watchdog_clear_instruction, .global_irq_enable, .irq_vector_taken,
   .timeout_irq, .watchdog_reset_pulse);

`default_nettype wire

// file: verilog/wdt_osc_tick.sv
// Divider that stands in for the dedicated watchdog oscillator.
// Assumes pclk runs continuously; emits a one-cycle enable at the tick rate.
`timescale 1ns/1ps
`default_nettype none

module wdt_osc_tick #(
   parameter int DIV = wdt_pkg::OSC_DIV
) (
   input  wire logic pclk,
   input  wire logic presetn,
   output logic      tick
);

   localparam int CW = $clog2(DIV + 1);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] div_r;

   // The tick ignores the CPU workload, so the watchdog period is fixed.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_r <= '0;
         tick  <= 1'b0;
      end
      else if (div_r == LAST)
      begin
         div_r <= '0;
         tick  <= 1'b1;
      end
      else
      begin
         div_r <= div_r + CW'(1);
         tick  <= 1'b0;
      end
   end

endmodule : wdt_osc_tick

`default_nettype wire

// file: verilog/wdt_pkg.sv
// Package holding offsets, field positions, reset values and counts for the
// watchdog with its reset-cause status register.
// Assumes a single 250 MHz register clock and APB access with 32-bit data.
//
// Overview of operation
// - Watchdog reset sets status bit 3; power-on or written zero clears it.
// - Brown-out reset sets status bit 2; power-on or written zero clears it.
// - External reset sets status bit 1; power-on or written zero clears it.
// - Power-on sets status bit 0; only a written zero clears it.
// - Counter advances on a 128 kHz tick independent of the CPU clock.
// - Counter clears on clear instruction, when disabled, and on chip reset.
// - Elapsed period in reset mode resets the chip.
// - Enable and interrupt enable select stopped, interrupt or reset mode.
// - Fuse selects safety level one or two with their own policies.
// - Interrupt-mode time-out sets bit 7; vector or written one clears it.
// - Interrupt is taken only with global and watchdog enables both set.
// - With enable set, a time-out clears interrupt enable at bit 6.
// - Change enable at bit 4 self-clears four cycles after being set.
// - Enable at bit 3 clears only inside the change window.
// - Period select changes only inside the change window.
// - Level two never disables the watchdog.
// - Level one forces enable while the watchdog reset flag is set.
// - Period code on bits 5,2,1,0 selects 2048 doubling to 1048576 ticks.
// - A watchdog time-out reset is a one-cycle internal reset pulse.
// - Level one enables the watchdog by a plain write of one.
// - Level two period change: open window, then one write of the period.

package wdt_pkg;

   localparam logic [11:0] ADDR_STATUS  = 12'h000;
   localparam logic [11:0] ADDR_CONTROL = 12'h004;

   localparam int BIT_WATCHDOG_RESET_FLAG  = 3;
   localparam int BIT_BROWNOUT_RESET_FLAG  = 2;
   localparam int BIT_EXTERNAL_PIN_RESET_FLAG = 1;
   localparam int BIT_POWER_ON_RESET_FLAG  = 0;

   localparam int BIT_IFLAG = 7;
   localparam int BIT_IEN   = 6;
   localparam int BIT_PSEL3 = 5;
   localparam int BIT_CWIN  = 4;
   localparam int BIT_EN    = 3;
   localparam int BIT_PSEL2 = 2;
   localparam int BIT_PSEL1 = 1;
   localparam int BIT_PSEL0 = 0;

   localparam logic [3:0] STATUS_RESET  = 4'h1;
   localparam logic [3:0] PERIOD_RESET  = 4'h0;
   localparam logic [3:0] PERIOD_MAXSEL = 4'h9;

   localparam int CLK_HZ       = 250000000;
   localparam int OSC_HZ       = 128000;
   localparam int OSC_DIV      = CLK_HZ / OSC_HZ;
   localparam int BASE_TICKS   = 2048;
   localparam int WINDOW_CYCLES = 4;
   localparam logic [2:0] WINDOW_LOAD = 3'(WINDOW_CYCLES);

endpackage : wdt_pkg

// file: verilog/wdt_top.sv
// Watchdog timer with its control register and the reset-cause status
// register, reached over APB.
// Assumes presetn is the power-on reset; other reset sources arrive as
// one-cycle event pulses synchronous to pclk.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module wdt_top #(
   parameter int OSC_DIV    = wdt_pkg::OSC_DIV,
   parameter int BASE_TICKS = wdt_pkg::BASE_TICKS,
   parameter int CNT_W      = 21
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        safety_level_fuse,
   input  wire logic        watchdog_clear_instruction,
   input  wire logic        brownout_reset_event,
   input  wire logic        external_reset_event,
   input  wire logic        global_irq_enable,
   input  wire logic        irq_vector_taken,
   output logic             timeout_irq,
   output logic             watchdog_reset_pulse
);

   logic             osc_tick;
   logic             setup_phase;
   logic             wr_en;
   logic             wr_status;
   logic             wr_control;
   logic             addr_hit;
   logic             chip_reset;
   logic             level2;
   logic             window_open;
   logic             open_write;
   logic             change_write;
   logic             en_eff;
   logic             running;
   logic             timeout;
   logic [3:0]       sel_eff;
   logic [CNT_W-1:0] limit;
   logic [7:0]       status_rd;
   logic [7:0]       control_rd;
   logic [3:0]       wr_period;

   logic             watchdog_reset_flag_r;
   logic             brownout_reset_flag_r;
   logic             external_pin_reset_flag_r;
   logic             power_on_reset_flag_r;
   logic             iflag_r;
   logic             ien_r;
   logic             en_r;
   logic [3:0]       period_r;
   logic [2:0]       win_cnt_r;
   logic [CNT_W-1:0] cnt_r;

   wdt_osc_tick #(
      .DIV     (OSC_DIV)
   ) u_osc (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (osc_tick)
   );

   assign setup_phase = psel & ~penable;
   assign wr_en       = psel & penable & pready & pwrite;
   assign wr_status   = wr_en & (paddr == wdt_pkg::ADDR_STATUS);
   assign wr_control  = wr_en & (paddr == wdt_pkg::ADDR_CONTROL);
   assign addr_hit    = (paddr == wdt_pkg::ADDR_STATUS) |
                        (paddr == wdt_pkg::ADDR_CONTROL);

   assign level2      = safety_level_fuse;
   assign window_open = (win_cnt_r != 3'h0);
   assign wr_period   = {pwdata[wdt_pkg::BIT_PSEL3], pwdata[wdt_pkg::BIT_PSEL2],
                         pwdata[wdt_pkg::BIT_PSEL1], pwdata[wdt_pkg::BIT_PSEL0]};

   // Opening the window takes change enable and enable written as ones.
   assign open_write   = wr_control & pwdata[wdt_pkg::BIT_CWIN] &
                         pwdata[wdt_pkg::BIT_EN];
   assign change_write = wr_control & window_open & ~open_write;

   // The own watchdog pulse is a chip reset one cycle after the time-out.
   assign chip_reset = watchdog_reset_pulse | brownout_reset_event |
                       external_reset_event;

   // Level two reads enable as one; level one lets the flag hold it set.
   assign en_eff  = level2 | en_r | watchdog_reset_flag_r;
   assign running = en_eff | ien_r;

   // Reserved codes fall back to the longest period.
   assign sel_eff = (period_r > wdt_pkg::PERIOD_MAXSEL) ?
                    wdt_pkg::PERIOD_MAXSEL : period_r;
   assign limit   = CNT_W'(BASE_TICKS) << sel_eff;

   // A clear in the final tick's cycle wins, so no time-out slips past it.
   assign timeout = running & osc_tick & ~watchdog_clear_instruction &
                    (cnt_r == limit - CNT_W'(1));

   assign status_rd  = {4'h0, watchdog_reset_flag_r, brownout_reset_flag_r, external_pin_reset_flag_r, power_on_reset_flag_r};
   assign control_rd = {iflag_r, ien_r, period_r[3], window_open, en_eff,
                        period_r[2:0]};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup_phase;
         pslverr <= setup_phase & ~addr_hit;
         if (setup_phase & ~pwrite & (paddr == wdt_pkg::ADDR_STATUS))
         begin
            prdata <= {24'h00_0000, status_rd};
         end
         else if (setup_phase & ~pwrite & (paddr == wdt_pkg::ADDR_CONTROL))
         begin
            prdata <= {24'h00_0000, control_rd};
         end
         else if (setup_phase)
         begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // Reset-cause flags: a new event wins over a write of zero.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_reset_flag_r  <= wdt_pkg::STATUS_RESET[wdt_pkg::BIT_WATCHDOG_RESET_FLAG];
         brownout_reset_flag_r  <= wdt_pkg::STATUS_RESET[wdt_pkg::BIT_BROWNOUT_RESET_FLAG];
         external_pin_reset_flag_r <= wdt_pkg::STATUS_RESET[wdt_pkg::BIT_EXTERNAL_PIN_RESET_FLAG];
         power_on_reset_flag_r  <= wdt_pkg::STATUS_RESET[wdt_pkg::BIT_POWER_ON_RESET_FLAG];
      end
      else
      begin
         if (watchdog_reset_pulse)
         begin
            watchdog_reset_flag_r <= 1'b1;
         end
         else if (wr_status & ~pwdata[wdt_pkg::BIT_WATCHDOG_RESET_FLAG])
         begin
            watchdog_reset_flag_r <= 1'b0;
         end
         if (brownout_reset_event)
         begin
            brownout_reset_flag_r <= 1'b1;
         end
         else if (wr_status & ~pwdata[wdt_pkg::BIT_BROWNOUT_RESET_FLAG])
         begin
            brownout_reset_flag_r <= 1'b0;
         end
         if (external_reset_event)
         begin
            external_pin_reset_flag_r <= 1'b1;
         end
         else if (wr_status & ~pwdata[wdt_pkg::BIT_EXTERNAL_PIN_RESET_FLAG])
         begin
            external_pin_reset_flag_r <= 1'b0;
         end
         if (wr_status & ~pwdata[wdt_pkg::BIT_POWER_ON_RESET_FLAG])
         begin
            power_on_reset_flag_r <= 1'b0;
         end
      end
   end

   // Change window counter; it closes after one accepted change.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         win_cnt_r <= 3'h0;
      end
      else if (chip_reset)
      begin
         win_cnt_r <= 3'h0;
      end
      else if (open_write)
      begin
         win_cnt_r <= wdt_pkg::WINDOW_LOAD;
      end
      else if (change_write)
      begin
         win_cnt_r <= 3'h0;
      end
      else if (window_open)
      begin
         win_cnt_r <= win_cnt_r - 3'h1;
      end
   end

   // Enable bit: set freely, cleared only inside the window.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         en_r <= 1'b0;
      end
      else if (chip_reset)
      begin
         en_r <= 1'b0;
      end
      else if (wr_control & pwdata[wdt_pkg::BIT_EN])
      begin
         en_r <= 1'b1;
      end
      else if (change_write & ~level2)
      begin
         en_r <= 1'b0;
      end
   end

   // Period select: only the write that follows an open window lands.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         period_r <= wdt_pkg::PERIOD_RESET;
      end
      else if (chip_reset)
      begin
         period_r <= wdt_pkg::PERIOD_RESET;
      end
      else if (change_write)
      begin
         period_r <= wr_period;
      end
   end

   // Interrupt enable: a time-out with enable set drops it to arm a reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ien_r <= 1'b0;
      end
      else if (chip_reset)
      begin
         ien_r <= 1'b0;
      end
      else if (timeout & ien_r & en_eff)
      begin
         ien_r <= 1'b0;
      end
      else if (wr_control)
      begin
         ien_r <= pwdata[wdt_pkg::BIT_IEN];
      end
   end

   // Interrupt flag: set wins over the vector and over a written one.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         iflag_r <= 1'b0;
      end
      else if (chip_reset)
      begin
         iflag_r <= 1'b0;
      end
      else if (timeout & ien_r)
      begin
         iflag_r <= 1'b1;
      end
      else if (irq_vector_taken |
               (wr_control & pwdata[wdt_pkg::BIT_IFLAG]))
      begin
         iflag_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timeout_irq <= 1'b0;
      end
      else
      begin
         timeout_irq <= iflag_r & ien_r & global_irq_enable & ~chip_reset
                        & ~irq_vector_taken;
      end
   end

   // The reset pulse lasts one pclk cycle; it is never raised in two
   // cycles in a row.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_reset_pulse <= 1'b0;
      end
      else
      begin
         watchdog_reset_pulse <= timeout & ~ien_r & en_eff
                                 & ~watchdog_reset_pulse;
      end
   end

   // Tick counter; a time-out restarts it from zero.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_r <= '0;
      end
      else if (chip_reset | watchdog_clear_instruction | ~running)
      begin
         cnt_r <= '0;
      end
      else if (timeout)
      begin
         cnt_r <= '0;
      end
      else if (osc_tick)
      begin
         cnt_r <= cnt_r + CNT_W'(1);
      end
   end

endmodule : wdt_top

`default_nettype wire
